// >>> hw/thu_cfg.svh
// Offsets, field positions, reset values and codes of the trap handling unit
`ifndef THU_CFG_SVH
`define THU_CFG_SVH
`define THU_REG_EN0      8'h00
`define THU_REG_EN1      8'h04
`define THU_REG_ST0      8'h08
`define THU_REG_ST1      8'h0c
`define THU_REG_BASE     8'h10
`define THU_REG_STATE    8'h14
`define THU_W_EN         2'h0
`define THU_W_ST         2'h1
`define THU_W_WP         2'h2
`define THU_W_IP         2'h3
`define THU_TRAPPED_OFS  32'h0000_0080
`define THU_GRP_BRK      2'h0
`define THU_GRP_ERR      2'h1
`define THU_GRP_SYS      2'h2
`define THU_GRP_SCHED    2'h3
`define THU_MASK_BRK     16'h0001
`define THU_MASK_ERR     16'h0006
`define THU_MASK_SYS     16'h0038
`define THU_MASK_SCHED   16'h3fc0
`define THU_BIT_LOAD     4
`define THU_BIT_STORE    5
`define THU_BIT_LAST     13
`define THU_BIT_CAUSE    15
`define THU_EN_RST       32'h0000_0000
`define THU_ST_RST       32'h0000_0000
`define THU_BASE_RST     32'h0000_0000
`endif

// >>> hw/thu_pkg.sv
// Types of the trap handling unit
package thu_pkg;
	typedef enum logic [2:0] {
		THU_OP_NONE  = 3'h0,
		THU_OP_LDH   = 3'h1,
		THU_OP_STH   = 3'h2,
		THU_OP_LDD   = 3'h3,
		THU_OP_STD   = 3'h4,
		THU_OP_ENB   = 3'h5,
		THU_OP_DIS   = 3'h6,
		THU_OP_RET   = 3'h7
	} thu_op_t;
	typedef enum logic [1:0] {
		THU_IDLE = 2'b00,
		THU_RD   = 2'b01,
		THU_WR   = 2'b11,
		THU_FIN  = 2'b10
	} thu_state_t;
	typedef enum logic [1:0] {
		THU_M_TAKE = 2'h0,
		THU_M_RET  = 2'h1,
		THU_M_COPY = 2'h2
	} thu_mode_t;
endpackage : thu_pkg

// >>> hw/thu_trap_unit.sv
// Trap handling unit: per-priority trap enables, status and context switch
//
// The register addresses and register access over AHB-Lite were decided locally.
`include "thu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module thu_trap_unit #(
	parameter int ADDR_W = 32
) (
	// Clock, reset, enable
	input  wire logic               clock,
	input  wire logic               arst_n,
	input  wire logic               clk_en,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [ADDR_W-1:0]  haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Trap conditions
	input  wire logic               cond_valid,
	input  wire logic [15:0]        cond_bits,
	input  wire logic               cond_pri,
	// Running process context
	input  wire logic               cur_pri,
	input  wire logic               intr_point,
	input  wire logic [31:0]        cur_iptr,
	input  wire logic [31:0]        cur_wptr,
	output logic                    trap_busy,
	output logic                    ctx_load,
	output logic      [31:0]        new_iptr,
	output logic      [31:0]        new_wptr,
	// Trap instructions
	input  wire logic               op_valid,
	input  wire thu_pkg::thu_op_t   op_code,
	input  wire logic [31:0]        op_a,
	input  wire logic [31:0]        op_b,
	input  wire logic [31:0]        op_c,
	output logic                    op_done,
	output logic      [31:0]        op_result,
	// Workspace memory
	output logic                    mem_req,
	output logic                    mem_we,
	output logic      [31:0]        mem_addr,
	output logic      [31:0]        mem_wdata,
	input  wire logic               mem_ready,
	input  wire logic [31:0]        mem_rdata
);
	import thu_pkg::*;

	generate
		if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
			$error("thu_trap_unit: ADDR_W must be 8 to 32");
		end
	endgenerate

	logic [31:0] en_reg   [2];
	logic [31:0] en_next  [2];
	logic [31:0] st_reg   [2];
	logic [31:0] st_next  [2];
	logic [1:0]  act_reg  [2];
	logic [1:0]  act_next [2];
	logic [31:0] buf_reg  [4];
	logic [31:0] buf_next [4];
	logic [31:0] set_vec  [2];
	logic [31:0] base_reg, base_next, hrdata_reg, hrdata_next;
	logic [31:0] src_reg, src_next, dst_reg, dst_next;
	logic [31:0] iptr_reg, iptr_next, wptr_reg, wptr_next, res_reg, res_next;
	logic [7:0]  wa_reg, wa_next;
	logic        wp_reg, wp_next, ld_reg, ld_next, done_reg, done_next;
	logic        pri_reg, pri_next;
	logic [1:0]  grp_reg, grp_next, idx_reg, idx_next;
	thu_state_t  state_reg, state_next;
	thu_mode_t   mode_reg, mode_next;
	logic [13:0] pend;
	logic        addr_ph;

	function automatic logic [15:0] grp_mask(input logic [1:0] g);
		case (g)
			`THU_GRP_BRK: grp_mask = `THU_MASK_BRK;
			`THU_GRP_ERR: grp_mask = `THU_MASK_ERR;
			`THU_GRP_SYS: grp_mask = `THU_MASK_SYS;
			default:      grp_mask = `THU_MASK_SCHED;
		endcase
	endfunction : grp_mask

	function automatic logic [1:0] first_grp(input logic [13:0] p);
		if (|(p & `THU_MASK_BRK))
			first_grp = `THU_GRP_BRK;
		else if (|(p & `THU_MASK_ERR))
			first_grp = `THU_GRP_ERR;
		else if (|(p & `THU_MASK_SYS))
			first_grp = `THU_GRP_SYS;
		else
			first_grp = `THU_GRP_SCHED;
	endfunction : first_grp

	// two structures, handler and trapped, per group and priority
	function automatic logic [31:0] struct_addr(input logic [31:0] b, input logic trapped,
		input logic p, input logic [1:0] g);
		struct_addr = b + (trapped ? `THU_TRAPPED_OFS : 32'h0) + {25'h0, p, g, 4'h0};
	endfunction : struct_addr

	generate
		for (genvar p = 0; p < 2; p++) begin : g_set
			logic [13:0] hit;
			assign hit = cond_bits[`THU_BIT_LAST:0] & en_reg[p][`THU_BIT_LAST:0];
			assign set_vec[p] = (cond_valid && cond_pri == p[0]) ?
				{16'h0, cond_bits[`THU_BIT_CAUSE] & (|hit), 1'b0, hit} : 32'h0;
		end
	endgenerate

	// pending only when flagged and enabled
	assign pend    = st_reg[cur_pri][`THU_BIT_LAST:0] & en_reg[cur_pri][`THU_BIT_LAST:0];
	assign addr_ph = hsel && hready && htrans[1];

	always_comb begin
		en_next     = en_reg;
		st_next     = st_reg;
		act_next    = act_reg;
		buf_next    = buf_reg;
		base_next   = base_reg;
		hrdata_next = hrdata_reg;
		src_next    = src_reg;
		dst_next    = dst_reg;
		iptr_next   = iptr_reg;
		wptr_next   = wptr_reg;
		res_next    = res_reg;
		pri_next    = pri_reg;
		grp_next    = grp_reg;
		idx_next    = idx_reg;
		state_next  = state_reg;
		mode_next   = mode_reg;
		wp_next     = addr_ph && hwrite;
		wa_next     = addr_ph ? haddr[7:0] : wa_reg;
		ld_next     = 1'b0;
		done_next   = 1'b0;
		// Read data is fetched in the address phase so no wait states are needed
		if (addr_ph && !hwrite) begin
			case (haddr[7:0])
				`THU_REG_EN0:   hrdata_next = en_reg[0];
				`THU_REG_EN1:   hrdata_next = en_reg[1];
				`THU_REG_ST0:   hrdata_next = st_reg[0];
				`THU_REG_ST1:   hrdata_next = st_reg[1];
				`THU_REG_BASE:  hrdata_next = base_reg;
				`THU_REG_STATE: hrdata_next = {24'h0, act_reg[1], act_reg[0], 2'h0, state_reg};
				default:        hrdata_next = 32'h0;
			endcase
		end
		if (wp_reg) begin
			case (wa_reg)
				`THU_REG_EN0:  en_next[0] = hwdata;
				`THU_REG_EN1:  en_next[1] = hwdata;
				`THU_REG_ST0:  st_next[0] = hwdata;
				`THU_REG_ST1:  st_next[1] = hwdata;
				`THU_REG_BASE: base_next = hwdata;
				default:       ;
			endcase
		end
		case (state_reg)
			THU_IDLE: begin
				idx_next = 2'h0;
				pri_next = cur_pri;
				// group in stack A, memory area in B
				grp_next = op_a[1:0];
				if (op_valid) begin
					case (op_code)
						THU_OP_ENB, THU_OP_DIS: begin
							res_next = {16'h0, en_reg[op_b[0]][15:0]};
							done_next = 1'b1;
							if (op_code == THU_OP_ENB)
								en_next[op_b[0]][15:0] = en_reg[op_b[0]][15:0] | op_a[15:0];
							else
								en_next[op_b[0]][15:0] = en_reg[op_b[0]][15:0] & ~op_a[15:0];
						end
						THU_OP_LDH, THU_OP_STH, THU_OP_LDD, THU_OP_STD: begin
							mode_next = THU_M_COPY;
							// monitored transfer becomes a trap flag
							if ((op_code == THU_OP_LDH || op_code == THU_OP_LDD)
								&& en_reg[cur_pri][`THU_BIT_LOAD]) begin
								st_next[cur_pri][`THU_BIT_LOAD] = 1'b1;
								done_next = 1'b1;
							end else if ((op_code == THU_OP_STH || op_code == THU_OP_STD)
								&& en_reg[cur_pri][`THU_BIT_STORE]) begin
								st_next[cur_pri][`THU_BIT_STORE] = 1'b1;
								done_next = 1'b1;
							end else begin
								state_next = THU_RD;
								// handler priority from C, trapped current
								case (op_code)
									THU_OP_LDH: begin
										src_next = op_b;
										dst_next = struct_addr(base_reg, 1'b0, op_c[0], op_a[1:0]);
									end
									THU_OP_STH: begin
										src_next = struct_addr(base_reg, 1'b0, op_c[0], op_a[1:0]);
										dst_next = op_b;
									end
									THU_OP_LDD: begin
										src_next = op_b;
										dst_next = struct_addr(base_reg, 1'b1, cur_pri, op_a[1:0]);
									end
									default: begin
										src_next = struct_addr(base_reg, 1'b1, cur_pri, op_a[1:0]);
										dst_next = op_b;
									end
								endcase
							end
						end
						THU_OP_RET: begin
							mode_next  = THU_M_RET;
							state_next = THU_RD;
							src_next   = struct_addr(base_reg, 1'b1, cur_pri, act_reg[cur_pri]);
						end
						default: done_next = 1'b1;
					endcase
				// trap taken at an interruptible point
				end else if (intr_point && pend != 14'h0) begin
					mode_next  = THU_M_TAKE;
					state_next = THU_RD;
					grp_next   = first_grp(pend);
					src_next   = struct_addr(base_reg, 1'b0, cur_pri, first_grp(pend));
					dst_next   = struct_addr(base_reg, 1'b1, cur_pri, first_grp(pend));
				end
			end
			THU_RD: begin
				if (mem_ready) begin
					buf_next[idx_reg] = mem_rdata;
					idx_next = idx_reg + 2'h1;
					if (idx_reg == 2'h3) begin
						// no handler installed, drop the group's flags
						if (mode_reg == THU_M_TAKE && buf_reg[`THU_W_WP] == 32'h0) begin
							state_next = THU_IDLE;
							st_next[pri_reg] = st_reg[pri_reg] & ~{16'h0, grp_mask(grp_reg)};
						end else begin
							state_next = (mode_reg == THU_M_RET) ? THU_FIN : THU_WR;
						end
					end
				end
			end
			THU_WR: begin
				if (mem_ready) begin
					idx_next = idx_reg + 2'h1;
					if (idx_reg == 2'h3)
						state_next = THU_FIN;
				end
			end
			THU_FIN: begin
				state_next = THU_IDLE;
				case (mode_reg)
					THU_M_TAKE: begin
						// handler context, enables ANDed not replaced
						ld_next = 1'b1;
						iptr_next = buf_reg[`THU_W_IP];
						wptr_next = buf_reg[`THU_W_WP];
						st_next[pri_reg] = buf_reg[`THU_W_ST];
						en_next[pri_reg] = en_reg[pri_reg] & buf_reg[`THU_W_EN];
						act_next[pri_reg] = grp_reg;
					end
					THU_M_RET: begin
						// restore and clear the trap flag
						ld_next = 1'b1;
						done_next = 1'b1;
						iptr_next = buf_reg[`THU_W_IP];
						wptr_next = buf_reg[`THU_W_WP];
						st_next[pri_reg] = buf_reg[`THU_W_ST]
							& ~{16'h0, grp_mask(act_reg[pri_reg]) | 16'h8000};
						en_next[pri_reg] = buf_reg[`THU_W_EN];
					end
					default: done_next = 1'b1;
				endcase
			end
			default: state_next = THU_IDLE;
		endcase
		// a new condition beats any clear
		for (int p = 0; p < 2; p++)
			st_next[p] = st_next[p] | set_vec[p];
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_reg     <= '{default: `THU_EN_RST};
			st_reg     <= '{default: `THU_ST_RST};
			act_reg    <= '{default: 2'h0};
			buf_reg    <= '{default: 32'h0};
			base_reg   <= `THU_BASE_RST;
			hrdata_reg <= 32'h0;
			src_reg    <= 32'h0;
			dst_reg    <= 32'h0;
			iptr_reg   <= 32'h0;
			wptr_reg   <= 32'h0;
			res_reg    <= 32'h0;
			wa_reg     <= 8'h0;
			wp_reg     <= 1'b0;
			ld_reg     <= 1'b0;
			done_reg   <= 1'b0;
			pri_reg    <= 1'b0;
			grp_reg    <= 2'h0;
			idx_reg    <= 2'h0;
			state_reg  <= THU_IDLE;
			mode_reg   <= THU_M_COPY;
		end else if (clk_en) begin
			en_reg     <= en_next;
			st_reg     <= st_next;
			act_reg    <= act_next;
			buf_reg    <= buf_next;
			base_reg   <= base_next;
			hrdata_reg <= hrdata_next;
			src_reg    <= src_next;
			dst_reg    <= dst_next;
			iptr_reg   <= iptr_next;
			wptr_reg   <= wptr_next;
			res_reg    <= res_next;
			wa_reg     <= wa_next;
			wp_reg     <= wp_next;
			ld_reg     <= ld_next;
			done_reg   <= done_next;
			pri_reg    <= pri_next;
			grp_reg    <= grp_next;
			idx_reg    <= idx_next;
			state_reg  <= state_next;
			mode_reg   <= mode_next;
		end
	end

	// word k of a structure sits at base plus 4k
	assign mem_addr  = ((state_reg == THU_WR) ? dst_reg : src_reg) + {28'h0, idx_reg, 2'h0};
	assign mem_req   = (state_reg == THU_RD) || (state_reg == THU_WR);
	assign mem_we    = (state_reg == THU_WR);

	// trapped structure takes the live context
	// cur_iptr already names the following instruction
	always_comb begin
		mem_wdata = buf_reg[idx_reg];
		if (mode_reg == THU_M_TAKE) begin
			case (idx_reg)
				`THU_W_IP: mem_wdata = cur_iptr;
				`THU_W_WP: mem_wdata = cur_wptr;
				`THU_W_ST: mem_wdata = st_reg[pri_reg];
				default:   mem_wdata = en_reg[pri_reg];
			endcase
		end
	end

	assign trap_busy = (state_reg != THU_IDLE);
	assign ctx_load  = ld_reg;
	assign new_iptr  = iptr_reg;
	assign new_wptr  = wptr_reg;
	assign op_done   = done_reg;
	assign op_result = res_reg;
	assign hrdata    = hrdata_reg;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

endmodule : thu_trap_unit
`default_nettype wire

// >>> verification/thu_mem_model.sv
// Workspace memory model answering the trap unit after a set latency
`timescale 1ns/100ps
`default_nettype none
module thu_mem_model (
	// Clock, reset, latency
	input  wire logic        clock,
	input  wire logic        arst_n,
	input  wire logic [3:0]  lat,
	// Memory port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	output logic             mem_ready,
	output logic [31:0]      mem_rdata
);
	logic [31:0] mem [0:255];
	logic [3:0]  cnt_reg;
	initial for (int i = 0; i < 256; i++) mem[i] = 32'h0;
	assign mem_ready = mem_req && (cnt_reg == lat);
	// Inverted word outside the ack so stale data never looks right
	assign mem_rdata = mem_ready ? mem[mem_addr[9:2]] : ~mem[mem_addr[9:2]];
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) cnt_reg <= 4'h0;
		else if (!mem_req || mem_ready) cnt_reg <= 4'h0;
		else cnt_reg <= cnt_reg + 4'h1;
	end
	always @(posedge clock) begin
		if (mem_ready && mem_we) mem[mem_addr[9:2]] <= mem_wdata;
	end
endmodule : thu_mem_model
`default_nettype wire

// >>> verification/thu_trap_unit_properties.sv
// Port checker of the trap handling unit and its bind
`timescale 1ns/100ps
`default_nettype none
module thu_trap_unit_properties
	import thu_pkg::*;
(
	// Clock and reset
	input wire logic             clock,
	input wire logic             arst_n,
	input wire logic             clk_en,
	// Instructions and context
	input wire logic             op_valid,
	input wire thu_pkg::thu_op_t op_code,
	input wire logic             op_done,
	input wire logic             intr_point,
	input wire logic             trap_busy,
	input wire logic             ctx_load,
	// Memory
	input wire logic             mem_req,
	input wire logic             mem_we,
	input wire logic [31:0]      mem_addr,
	input wire logic             mem_ready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	logic take;
	assign take = op_valid && !trap_busy && clk_en;
	sequence s_ret_take; take && op_code == THU_OP_RET; endsequence
	sequence s_ret_end; ##[4:1000] (op_done && ctx_load); endsequence
	sequence s_copy_take; take && op_code inside {THU_OP_LDH, THU_OP_STH, THU_OP_LDD, THU_OP_STD};
	endsequence
	property p_ret; s_ret_take |=> s_ret_end; endproperty
	property p_copy; s_copy_take |-> ##[1:1000] op_done; endproperty
	property p_enb; take && op_code == THU_OP_ENB |=> op_done; endproperty
	property p_dis; take && op_code == THU_OP_DIS |=> op_done; endproperty
	property p_idle; !trap_busy && !op_valid && !intr_point |=> !trap_busy; endproperty
	property p_ctx; ctx_load |=> !ctx_load; endproperty
	property p_hold; mem_req && !mem_ready && clk_en |=> mem_req && $stable(mem_addr)
		&& $stable(mem_we); endproperty
	property p_word; mem_req |-> mem_addr[1:0] == 2'b00 && trap_busy; endproperty
	a_ret: assert property (p_ret) else $error("return not finished");
	a_copy: assert property (p_copy) else $error("transfer not done");
	a_enb: assert property (p_enb) else $error("enable not done");
	a_dis: assert property (p_dis) else $error("disable not done");
	a_idle: assert property (p_idle) else $error("trap off point");
	a_ctx: assert property (p_ctx) else $error("context load too long");
	a_hold: assert property (p_hold) else $error("memory request moved");
	a_word: assert property (p_word) else $error("bad memory access");
endmodule : thu_trap_unit_properties
bind thu_trap_unit thu_trap_unit_properties thu_trap_unit_properties_i (.clock(clock),
	.arst_n(arst_n), .clk_en(clk_en), .op_valid(op_valid), .op_code(op_code),
	.op_done(op_done), .intr_point(intr_point), .trap_busy(trap_busy), .ctx_load(ctx_load),
	.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_ready(mem_ready));
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking testbench of the trap handling unit
`include "thu_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import thu_pkg::*;
	logic        clock = 1'b0, arst_n = 1'b0, clk_en = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0]  htrans = 2'h0;
	logic        hreadyout, hresp, trap_busy, ctx_load, op_done, mem_req, mem_we, mem_ready;
	logic        cond_valid = 1'b0, cond_pri = 1'b0, intr_point = 1'b0, op_valid = 1'b0;
	logic [15:0] cond_bits = 16'h0;
	logic [31:0] new_iptr, new_wptr, op_result, mem_addr, mem_wdata, mem_rdata;
	logic [31:0] op_a = 32'h0, op_b = 32'h0, op_c = 32'h0;
	logic [3:0]  lat = 4'h0;
	logic        cur_pri = 1'b0;
	thu_op_t     op_code = THU_OP_NONE;
	thu_op_t     sk_op [4] = '{THU_OP_LDH, THU_OP_LDD, THU_OP_STH, THU_OP_STD};
	logic [9:0]  sk_b [4] = '{10'h40, 10'h40, 10'h70, 10'h70};
	logic [9:0]  sk_dst [4] = '{10'h108, 10'h188, 10'h78, 10'h78};
	int          mismatches = 0, n_checks = 0, cycles = 0;
	thu_trap_unit thu_trap_unit_i (.clock(clock), .arst_n(arst_n), .clk_en(clk_en),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .cond_valid(cond_valid), .cond_bits(cond_bits), .cond_pri(cond_pri),
		.cur_pri(cur_pri), .intr_point(intr_point), .cur_iptr(32'ha0), .cur_wptr(32'hb0),
		.trap_busy(trap_busy), .ctx_load(ctx_load), .new_iptr(new_iptr), .new_wptr(new_wptr),
		.op_valid(op_valid), .op_code(op_code), .op_a(op_a), .op_b(op_b), .op_c(op_c),
		.op_done(op_done), .op_result(op_result), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
		.mem_rdata(mem_rdata));
	thu_mem_model thu_mem_model_i (.clock(clock), .arst_n(arst_n), .lat(lat),
		.mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata));
	always #2.5 clock = ~clock;
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Hang guard, run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, g);
			mismatches++;
		end
	endtask : check
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clock);
		while (hreadyout !== 1'b1) @(posedge clock);
		rd = hrdata;
	endtask : ahb
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
		ahb(1'b0, a, 32'h0);
		check(n, e, rd);
	endtask : rd_chk
	task automatic op(input thu_op_t c, input logic [31:0] a, b, cc);
		op_valid <= 1'b1;
		op_code <= c;
		op_a <= a;
		op_b <= b;
		op_c <= cc;
		@(posedge clock);
		while (trap_busy !== 1'b0) @(posedge clock);
		op_valid <= 1'b0;
		@(posedge clock);
		while (op_done !== 1'b1) @(posedge clock);
	endtask : op
	task automatic cond(input logic [15:0] b, input logic p);
		cond_valid <= 1'b1;
		cond_bits <= b;
		cond_pri <= p;
		@(posedge clock);
		cond_valid <= 1'b0;
		@(posedge clock);
	endtask : cond
	function automatic logic [31:0] mw(input logic [9:0] a);
		return thu_mem_model_i.mem[a[9:2]];
	endfunction : mw
	task automatic put4(input logic [9:0] a, input logic [31:0] w0, w2, w3);
		thu_mem_model_i.mem[a[9:2]] = w0;
		thu_mem_model_i.mem[a[9:2] + 8'h2] = w2;
		thu_mem_model_i.mem[a[9:2] + 8'h3] = w3;
	endtask : put4
	initial begin
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0, "reset value");
		ahb(1'b1, 8'h18, 32'h5a5a_5a5a);
		rd_chk(8'h18, 32'h0, "unmapped");
		op(THU_OP_ENB, 32'h0001_0007, 32'h0, 32'h0);
		check("enb old", 32'h0, op_result);
		op(THU_OP_ENB, 32'h38, 32'h1, 32'h0);
		op(THU_OP_DIS, 32'h2, 32'h0, 32'h0);
		check("dis old", 32'h7, op_result);
		rd_chk(`THU_REG_EN0, 32'h5, "en0");
		rd_chk(`THU_REG_EN1, 32'h38, "en1");
		cond(16'h0002, 1'b0);
		cond(16'h0008, 1'b1);
		rd_chk(`THU_REG_ST0, 32'h0, "st0 masked");
		rd_chk(`THU_REG_ST1, 32'h8, "st1");
		cond(16'h0005, 1'b0);
		rd_chk(`THU_REG_ST0, 32'h5, "st0");
		ahb(1'b1, `THU_REG_BASE, 32'h100);
		// Handler masks its own group, group 0 left null
		put4(10'h110, 32'hffff_fff9, 32'h2000, 32'h3000);
		lat <= 4'h2;
		intr_point <= 1'b1;
		@(posedge clock);
		while (ctx_load !== 1'b1) @(posedge clock);
		intr_point <= 1'b0;
		check("new iptr", 32'h3000, new_iptr);
		check("new wptr", 32'h2000, new_wptr);
		check("saved en", 32'h5, mw(10'h190));
		check("saved st", 32'h4, mw(10'h194));
		check("saved wp", 32'hb0, mw(10'h198));
		check("saved ip", 32'ha0, mw(10'h19c));
		check("null grp", 32'h0, mw(10'h188));
		rd_chk(`THU_REG_STATE, 32'h10, "active grp");
		rd_chk(`THU_REG_EN0, 32'h1, "en anded");
		op(THU_OP_RET, 32'h0, 32'h0, 32'h0);
		check("ret load", 32'h1, {31'h0, ctx_load});
		check("ret iptr", 32'ha0, new_iptr);
		check("ret wptr", 32'hb0, new_wptr);
		rd_chk(`THU_REG_EN0, 32'h5, "ret en");
		rd_chk(`THU_REG_ST0, 32'h0, "ret st");
		put4(10'h160, 32'h11, 32'h13, 32'h14);
		op(THU_OP_STH, 32'h2, 32'h40, 32'h1);
		check("sth w0", 32'h11, mw(10'h40));
		check("sth w3", 32'h14, mw(10'h4c));
		lat <= 4'h0;
		op(THU_OP_LDD, 32'h3, 32'h40, 32'h1);
		check("ldd cur", 32'h13, mw(10'h1b8));
		check("ldd other", 32'h0, mw(10'h1f8));
		op(THU_OP_ENB, 32'h30, 32'h0, 32'h0);
		for (int i = 0; i < 4; i++) begin
			op(sk_op[i], 32'h0, {22'h0, sk_b[i]}, 32'h0);
			check("skipped", 32'h0, mw(sk_dst[i]));
		end
		rd_chk(`THU_REG_ST0, 32'h30, "skip flags");
		cond(16'h8001, 1'b0);
		rd_chk(`THU_REG_ST0, 32'h8031, "cause flag");
		// Priority 1 has load trap enabled, so the transfer is skipped there
		cur_pri <= 1'b1;
		op(THU_OP_LDD, 32'h3, 32'h40, 32'h0);
		check("pri1 skip", 32'h0, mw(10'h1f8));
		rd_chk(`THU_REG_ST1, 32'h18, "st1 skip");
		cur_pri <= 1'b0;
		// A write while frozen is lost
		clk_en <= 1'b0;
		ahb(1'b1, `THU_REG_EN1, 32'hffff);
		clk_en <= 1'b1;
		rd_chk(`THU_REG_EN1, 32'h38, "frozen");
		end_sim();
	end
endmodule : testbench
`default_nettype wire
